// file: src/dioad_match.sv
// window decoder: start address from switch weights plus byte offset
`timescale 1ns/1ps
module dioad_match (
  // switches and access
  input  wire logic [7:0] addr_switch_i,
  input  wire logic [2:0] byte_count_i,
  input  wire logic [7:0] bus_addr_i,
  // result
  output logic            hit_o,
  output logic [1:0]      offset_o
);
  logic [7:0] start;
  logic [8:0] diff;
  logic [7:0] weight  [8];
  logic [7:0] partial [9];

  // summed per rocker so each switch keeps its own binary weight
  assign partial[0] = 8'h00;
  for (genvar i = 0; i < 8; i++) begin : g_weight
    assign weight[i]      = addr_switch_i[i] ? (8'h01 << i) : 8'h00; // RL1
    assign partial[i + 1] = partial[i] + weight[i];
  end
  assign start = partial[8];

  always_comb begin
    diff     = {1'b0, bus_addr_i} - {1'b0, start};
    hit_o    = (diff[8] == 1'b0) && (diff < {6'h00, byte_count_i}); // RL13 RL3
    offset_o = diff[1:0];
  end
endmodule

// file: src/dioad_pkg.sv
// types for the digital i/o module address decode
package dioad_pkg;
  `include "dioad_regs.svh"

  typedef logic [`DIOAD_ADDR_W-1:0] dioad_addr_t;
  typedef logic [`DIOAD_DATA_W-1:0] dioad_byte_t;

  typedef enum logic [1:0] {
    DIOAD_IN_ONLY  = 2'b00,
    DIOAD_OUT_ONLY = 2'b01,
    DIOAD_MIXED    = 2'b10
  } dioad_kind_t;

  typedef enum logic [1:0] {
    DIOAD_IDLE  = 2'b00,
    DIOAD_READ  = 2'b01,
    DIOAD_WRITE = 2'b10
  } dioad_acc_t;
endpackage

// file: src/dioad_regs.svh
// constants for the digital i/o module address decode
`ifndef DIOAD_REGS_SVH
`define DIOAD_REGS_SVH

`define DIOAD_ADDR_W       8
`define DIOAD_DATA_W       8
`define DIOAD_MIXED_MAX    8'hFC
`define DIOAD_BYTES_1      3'h1
`define DIOAD_BYTES_2      3'h2
`define DIOAD_BYTES_4      3'h4
`define DIOAD_IDX_OUT0     2'h0
`define DIOAD_IDX_BIDIR    2'h1
`define DIOAD_IDX_IN2      2'h2
`define DIOAD_IDX_IN3      2'h3
`define DIOAD_OUT_RESET    8'h00
`define DIOAD_MODE_SOLO    1'b1

`endif

// file: src/dioad_top.sv
// bus side of a digital input/output module with switch addressing
`timescale 1ns/1ps
`include "dioad_regs.svh"
// Function
// RL1 - The byte address is the sum of the weights of the switches set on.
// RL2 - Plain modules accept addresses 0 to 255, the mixed module starts at 252 at most.
// RL3 - Multi-byte modules take the switch value as start and decode following bytes inside.
// RL4 - Decoding uses only the switches and never the slot position.
// RL5 - Reads serve inputs and writes serve outputs, so shared addresses do not clash.
// RL6 - The configuring party must not reuse an address of the same direction.
// RL7 - The mixed module has byte 0 outputs, bytes 2 and 3 inputs, byte 1 either way.
// RL8 - Byte 1 is an input when read and an output when written.
// RL9 - The byte 1 output register can be read back over the bus.
// RL10 - All output register bits clear to 0 after power-up.
// RL11 - Software keeps byte 1 outputs at 0 when used as inputs and leaves unused channels alone.
// RL12 - The mode slide switch must be at position 1 for standalone operation. The code checks the switch for the mixed module only.
// RL13 - The module answers only for addresses from start to start plus byte count minus one.
module dioad_top (
  // clock and reset
  input  wire logic                clock_i,
  input  wire logic                sys_rst_i,
  // configuration
  input  wire dioad_pkg::dioad_kind_t kind_i,
  input  wire logic [2:0]          byte_count_i,
  input  wire logic [7:0]          addr_switch_i,
  input  wire logic                mode_slide_switch_i,
  // backplane bus
  input  wire logic                bus_rd_i,
  input  wire logic                bus_wr_i,
  input  wire dioad_pkg::dioad_addr_t bus_addr_i,
  input  wire dioad_pkg::dioad_byte_t bus_wdata_i,
  output dioad_pkg::dioad_byte_t   bus_rdata_o,
  output logic                     bus_ack_o,
  // process side
  input  wire logic [31:0]         proc_in_i,
  output logic [31:0]              proc_out_o,
  output logic                     config_err_o
);
  import dioad_pkg::*;

  // ==========================================================
  // decode
  logic       hit;
  logic [1:0] offset;
  logic       start_ok;
  logic       rd_sel;
  logic       wr_sel;

  // slot never enters: only switches, byte count and bus address
  dioad_match u_match (
    .addr_switch_i (addr_switch_i), // RL4
    .byte_count_i  (byte_count_i),
    .bus_addr_i    (bus_addr_i),
    .hit_o         (hit),
    .offset_o      (offset)
  );

  // mixed module is always four bytes and limited in start
  always_comb begin
    start_ok = (kind_i != DIOAD_MIXED) || (addr_switch_i <= `DIOAD_MIXED_MAX); // RL2
    if (kind_i == DIOAD_MIXED) begin
      start_ok = start_ok && (byte_count_i == `DIOAD_BYTES_4) && mode_slide_switch_i;
    end
    // reads only touch input sides, writes only output sides
    rd_sel = bus_rd_i && !bus_wr_i && hit && start_ok && (kind_i != DIOAD_OUT_ONLY); // RL5
    wr_sel = bus_wr_i && !bus_rd_i && hit && start_ok && (kind_i != DIOAD_IN_ONLY);  // RL5
    if (kind_i == DIOAD_MIXED) begin
      // byte 0 writes only, bytes 2 and 3 read only, byte 1 both
      rd_sel = rd_sel && (offset != `DIOAD_IDX_OUT0); // RL7
      wr_sel = wr_sel && (offset == `DIOAD_IDX_OUT0 || offset == `DIOAD_IDX_BIDIR); // RL7 RL8
    end
  end

  // ==========================================================
  // output registers and read data
  logic [3:0][7:0] out_reg;
  logic [3:0][7:0] next_out_reg;
  dioad_byte_t     rdata;
  dioad_byte_t     next_rdata;
  logic            ack;
  logic            next_ack;

  always_comb begin
    next_out_reg = out_reg;
    next_rdata   = rdata;
    next_ack     = rd_sel || wr_sel;
    if (wr_sel) begin
      next_out_reg[offset] = bus_wdata_i; // RL8
    end
    if (rd_sel) begin
      if (kind_i == DIOAD_MIXED && offset == `DIOAD_IDX_BIDIR) begin
        // pins and held output merge: a zero output leaves the input visible
        next_rdata = proc_in_i[15:8] | out_reg[1]; // RL9 RL8 RL11
      end else begin
        next_rdata = proc_in_i[8*offset +: 8];
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_reg <= {4{`DIOAD_OUT_RESET}}; // RL10
      rdata   <= `DIOAD_OUT_RESET;
      ack     <= 1'b0;
    end else begin
      out_reg <= next_out_reg;
      rdata   <= next_rdata;
      ack     <= next_ack;
    end
  end

  assign bus_rdata_o  = rdata;
  assign bus_ack_o    = ack;
  assign proc_out_o   = out_reg;
  assign config_err_o = !start_ok; // RL12

  // ==========================================================
  // checks
  sequence s_write_hit;
    wr_sel;
  endsequence

  sequence s_read_hit;
    rd_sel;
  endsequence

  sequence s_bidir_write;
    wr_sel && kind_i == DIOAD_MIXED && offset == `DIOAD_IDX_BIDIR;
  endsequence

  sequence s_acc_taken;
    rd_sel || wr_sel;
  endsequence

  a_reset_clears: assert property (@(posedge clock_i)
    $fell(sys_rst_i) |-> proc_out_o == 32'h0000_0000) // RL10
    else $error("outputs not cleared after reset");

  a_write_stores: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_write_hit |=> proc_out_o[8*$past(offset) +: 8] == $past(bus_wdata_i)) // RL8
    else $error("write data not stored");

  a_no_stray_ack: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !hit |=> !bus_ack_o) // RL13
    else $error("ack outside address window");

  a_read_inputs: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (rd_sel && kind_i == DIOAD_IN_ONLY) |=> bus_rdata_o == $past(proc_in_i[8*offset +: 8])) // RL5
    else $error("read data mismatch");

  a_mixed_limit: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (kind_i == DIOAD_MIXED && addr_switch_i > `DIOAD_MIXED_MAX) |-> !rd_sel && !wr_sel) // RL2
    else $error("mixed start above limit accepted");

  a_byte0_wonly: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (kind_i == DIOAD_MIXED && offset == `DIOAD_IDX_OUT0) |-> !rd_sel) // RL7
    else $error("output byte read");

  a_readback: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (rd_sel && kind_i == DIOAD_MIXED && offset == `DIOAD_IDX_BIDIR)
      |=> (bus_rdata_o & $past(out_reg[1])) == $past(out_reg[1])) // RL9
    else $error("readback lost");

  a_read_no_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (bus_rd_i && !bus_wr_i) |=> $stable(proc_out_o)) // RL5
    else $error("read changed outputs");

  a_ack_follows: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_acc_taken |=> bus_ack_o) // RL13
    else $error("accepted access not acknowledged");

  a_ack_single: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    bus_ack_o |-> $past(rd_sel || wr_sel)) // RL13
    else $error("ack without accepted access");

  a_both_strobes: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (bus_rd_i && bus_wr_i) |=> !bus_ack_o) // RL5
    else $error("read and write together acknowledged");

  a_rdata_holds: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !rd_sel |=> $stable(bus_rdata_o)) // RL9
    else $error("read data moved without a read");

  a_in_only_keeps: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (bus_wr_i && kind_i == DIOAD_IN_ONLY) |=> $stable(proc_out_o)) // RL5
    else $error("input module took a write");

  a_out_only_quiet: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (bus_rd_i && kind_i == DIOAD_OUT_ONLY) |=> !bus_ack_o) // RL5
    else $error("output module answered a read");

  a_inputs_no_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (kind_i == DIOAD_MIXED && offset[1]) |-> !wr_sel) // RL7
    else $error("input byte written");

  a_mixed_count: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (kind_i == DIOAD_MIXED && byte_count_i != `DIOAD_BYTES_4) |-> config_err_o) // RL7
    else $error("mixed byte count not flagged");

  a_slide_needed: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (kind_i == DIOAD_MIXED && !mode_slide_switch_i) |-> config_err_o) // RL12
    else $error("slide switch position not flagged");

  a_limit_flagged: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (kind_i == DIOAD_MIXED && addr_switch_i > `DIOAD_MIXED_MAX) |-> config_err_o) // RL2
    else $error("mixed start limit not flagged");

  a_plain_no_err: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (kind_i != DIOAD_MIXED) |-> !config_err_o) // RL2
    else $error("plain module flagged");

  a_hit_above: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    hit |-> bus_addr_i >= addr_switch_i) // RL13
    else $error("hit below start address");

  a_hit_below: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    hit |-> ({1'b0, bus_addr_i} < ({1'b0, addr_switch_i} + 9'(byte_count_i)))) // RL3
    else $error("hit beyond last byte");

  a_offset_diff: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    hit |-> offset == 2'(bus_addr_i - addr_switch_i)) // RL3
    else $error("byte offset wrong");

  a_byte1_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_bidir_write |=> proc_out_o[15:8] == $past(bus_wdata_i)) // RL8
    else $error("byte 1 write not stored");

  a_read_keeps_out: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_read_hit |=> $stable(proc_out_o)) // RL9
    else $error("accepted read disturbed outputs");

  a_upper_reads: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (rd_sel && kind_i == DIOAD_MIXED && offset[1])
      |=> bus_rdata_o == $past(proc_in_i[8*offset +: 8])) // RL7
    else $error("input byte read data mismatch");
endmodule

// file: test/dioad_cpu_model.sv
// cpu side bus master model for the digital i/o address decode
`timescale 1ns/1ps
module dioad_cpu_model (
  // clock
  input  wire logic                clock_i,
  // answer from the module
  input  wire dioad_pkg::dioad_byte_t bus_rdata_i,
  input  wire logic                bus_ack_i,
  // access strobes
  output logic                     bus_rd_o,
  output logic                     bus_wr_o,
  output dioad_pkg::dioad_addr_t   bus_addr_o,
  output dioad_pkg::dioad_byte_t   bus_wdata_o
);
  import dioad_pkg::*;
  // ==========================================================
  // one-cycle access
  initial begin
    bus_rd_o = 1'b0;
    bus_wr_o = 1'b0;
    bus_addr_o = 8'h00;
    bus_wdata_o = 8'h00;
  end
  task automatic acc(input logic w, input dioad_addr_t a, input dioad_byte_t d,
                     output logic k, output dioad_byte_t q);
    @(posedge clock_i);
    bus_rd_o <= ~w;
    bus_wr_o <= w;
    bus_addr_o <= a;
    bus_wdata_o <= d;
    @(posedge clock_i);
    bus_rd_o <= 1'b0;
    bus_wr_o <= 1'b0;
    // released lines invert so a stale copy never matches
    bus_addr_o <= ~a;
    bus_wdata_o <= ~d;
    #1 k = bus_ack_i;
    q = bus_rdata_i;
  endtask
endmodule

// file: test/dioad_top_tb_top.sv
// self-checking bench for the digital i/o address decode
`timescale 1ns/1ps
module dioad_top_tb_top;
  import dioad_pkg::*;
  logic        clock_i, sys_rst_i, slide, rd, wr, k, ack, err;
  dioad_kind_t kind;
  logic [2:0]  cnt;
  dioad_addr_t sw, addr;
  dioad_byte_t wd, rq, q;
  logic [31:0] pin, pout;
  int          error_cnt, checked;
  dioad_top dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .kind_i(kind),
    .byte_count_i(cnt), .addr_switch_i(sw), .mode_slide_switch_i(slide),
    .bus_rd_i(rd), .bus_wr_i(wr), .bus_addr_i(addr), .bus_wdata_i(wd),
    .bus_rdata_o(rq), .bus_ack_o(ack), .proc_in_i(pin), .proc_out_o(pout),
    .config_err_o(err));
  dioad_cpu_model cpu_u (.clock_i(clock_i), .bus_rdata_i(rq), .bus_ack_i(ack),
    .bus_rd_o(rd), .bus_wr_o(wr), .bus_addr_o(addr), .bus_wdata_o(wd));
  // ==========================================================
  // helpers
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic ck(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic ac(input logic w, input dioad_addr_t a, input dioad_byte_t d, input logic e);
    cpu_u.acc(w, a, d, k, q);
    ck("ack", k, e);
  endtask
  task automatic cfg(input dioad_kind_t t, input logic [2:0] c, input dioad_addr_t s,
                     input logic m);
    @(posedge clock_i);
    kind <= t;
    cnt <= c;
    sw <= s;
    slide <= m;
    repeat (2) @(posedge clock_i);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    ck("out", pout, 32'h0);
    ck("ack", ack, 1'b0);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    #1 ck("out", pout, 32'h0);
  endtask
  task automatic t_plain;
    cfg(DIOAD_OUT_ONLY, 3'h2, 8'h17, 1'b1);
    ac(1'b1, 8'h17, 8'hA5, 1'b1);
    ac(1'b1, 8'h18, 8'h3C, 1'b1);
    ac(1'b1, 8'h19, 8'hFF, 1'b0);
    ac(1'b1, 8'h16, 8'hFF, 1'b0);
    ac(1'b0, 8'h17, 8'h00, 1'b0);
    ck("out", pout[15:0], 16'h3CA5);
    cfg(DIOAD_IN_ONLY, 3'h1, 8'hFF, 1'b1);
    ac(1'b0, 8'hFF, 8'h00, 1'b1);
    ck("rdata", q, pin[7:0]);
    ac(1'b1, 8'hFF, 8'h12, 1'b0);
  endtask
  task automatic t_mixed;
    @(posedge clock_i);
    pin <= 32'h9617E24B;
    cfg(DIOAD_MIXED, 3'h4, 8'hFC, 1'b1);
    ck("cfg", err, 1'b0);
    ac(1'b1, 8'hFC, 8'h81, 1'b1);
    ac(1'b0, 8'hFC, 8'h00, 1'b0);
    ac(1'b1, 8'hFE, 8'h55, 1'b0);
    ac(1'b1, 8'hFD, 8'h00, 1'b1);
    ac(1'b0, 8'hFD, 8'h00, 1'b1);
    ck("rdata", q, pin[15:8]);
    ac(1'b0, 8'hFF, 8'h00, 1'b1);
    ck("rdata", q, pin[31:24]);
    ac(1'b0, 8'hFE, 8'h00, 1'b1);
    ck("rdata", q, pin[23:16]);
    ac(1'b1, 8'hFD, 8'h0F, 1'b1);
    ac(1'b0, 8'hFD, 8'h00, 1'b1);
    ck("rdata", q, pin[15:8] | 8'h0F);
    ck("out", pout[15:0], 16'h0F81);
    cfg(DIOAD_MIXED, 3'h4, 8'hFD, 1'b1);
    ck("cfg", err, 1'b1);
    ac(1'b1, 8'hFD, 8'hF0, 1'b0);
    cfg(DIOAD_MIXED, 3'h4, 8'hFC, 1'b0);
    ck("cfg", err, 1'b1);
    ac(1'b1, 8'hFD, 8'hF0, 1'b0);
  endtask
  initial begin
    kind = DIOAD_IN_ONLY;
    cnt = 3'h1;
    sw = 8'h00;
    slide = 1'b1;
    pin = 32'hC3A55A3C;
    sys_rst_i = 1'b1;
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_plain();
    t_reset();
    t_mixed();
    tally_and_finish();
  end
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
